// >>> hw/sei_pkg.sv
package sei_pkg;
  // bus clock period
  localparam int CLK_PERIOD_NS = 5;
  // longest wait from buffer move to tx-empty set again, in bus cycles
  localparam int TXE_REFILL_MAX_CYC = 2;
  // master serial clock half period; rate selection is outside this block
  localparam int MASTER_HALF_NS = 20;
  localparam int MASTER_HALF_CYC = (MASTER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HALF_DIV_LAST = 8'(MASTER_HALF_CYC - 1);
  // master half-cycle indices: sixteen halves per byte, bit 1 captured entering 13
  localparam logic [3:0] HALF_FIRST = 4'h0;
  localparam logic [3:0] HALF_BIT1 = 4'hd;
  localparam logic [3:0] HALF_FINAL = 4'hf;
  // slave edge counts: seventh capture is bit 1, eighth is the last bit
  localparam logic [2:0] SAMPLE_BIT1 = 3'h6;
  localparam logic [2:0] EDGE_LAST = 3'h7;
  localparam logic [2:0] EDGE_FIRST = 3'h0;
  // reset values
  localparam logic TXE_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // synchroniser order {start, end_d, end_s, bit1, miso, ss_n}; ss_n idles high
  localparam logic [5:0] SYNC_RST = 6'h01;
  // master serial engine
  typedef enum logic [0:0] {M_IDLE, M_RUN} sei_mstate_t;
endpackage

// >>> hw/sei_slave_link.sv
`timescale 1ns/10ps
// slave shifter on the incoming serial clock; hold is high while deselected
module sei_slave_link (
  // link clock and resets
  input  wire logic       link_sclk,
  input  wire logic       hold,
  input  wire logic       link_rst,
  // static format, changed only while the port is disabled
  input  wire logic       cpol,
  input  wire logic       cpha,
  // serial data
  input  wire logic       mosi_i,
  output logic            miso_o,
  // towards the bus-clock side
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output logic            start_tgl,
  output logic            bit1_tgl,
  output logic            end_s_tgl,
  output logic            end_d_tgl
);
  logic       samp_clk;
  logic [2:0] scnt_reg;
  logic [2:0] dcnt_reg;
  logic [6:0] in_reg;
  logic       miso_reg;

  // capture edge is always rising here, whatever the format
  assign samp_clk = link_sclk ^ cpol ^ cpha;
  // phase 0 must show the msb before any edge
  assign miso_o = (!cpha && dcnt_reg == sei_pkg::EDGE_FIRST) ? tx_byte[7] : miso_reg;

  always_ff @(posedge samp_clk or posedge hold) begin
    if (hold) begin
      scnt_reg <= sei_pkg::EDGE_FIRST;
      in_reg   <= 7'h00;
    end else begin
      scnt_reg <= scnt_reg + 3'h1;
      in_reg   <= {in_reg[5:0], mosi_i};
    end
  end

  // capture-edge events; toggles survive deselect so none is faked
  always_ff @(posedge samp_clk or posedge link_rst) begin
    if (link_rst) begin
      rx_byte   <= sei_pkg::BYTE_RST;
      bit1_tgl  <= 1'b0;
      end_s_tgl <= 1'b0;
    end else if (!hold) begin
      if (scnt_reg == sei_pkg::SAMPLE_BIT1) begin
        bit1_tgl <= ~bit1_tgl;
      end
      if (scnt_reg == sei_pkg::EDGE_LAST) begin
        rx_byte <= {in_reg, mosi_i};
        if (cpha) begin
          end_s_tgl <= ~end_s_tgl;
        end
      end
    end
  end

  // drive edge: next bit out
  always_ff @(negedge samp_clk or posedge hold) begin
    if (hold) begin
      dcnt_reg <= sei_pkg::EDGE_FIRST;
      miso_reg <= 1'b0;
    end else begin
      dcnt_reg <= dcnt_reg + 3'h1;
      miso_reg <= cpha ? tx_byte[~dcnt_reg] : tx_byte[~(dcnt_reg + 3'h1)];
    end
  end

  // drive-edge events
  always_ff @(negedge samp_clk or posedge link_rst) begin
    if (link_rst) begin
      start_tgl <= 1'b0;
      end_d_tgl <= 1'b0;
    end else if (!hold) begin
      if (cpha && dcnt_reg == sei_pkg::EDGE_FIRST) begin
        start_tgl <= ~start_tgl;
      end
      // phase 0 ends back at idle
      if (!cpha && dcnt_reg == sei_pkg::EDGE_LAST) begin
        end_d_tgl <= ~end_d_tgl;
      end
    end
  end
endmodule // sei_slave_link

// >>> hw/sei_error_irq.sv
`timescale 1ns/10ps
module sei_error_irq (
  // clocks and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       link_sclk,
  // control register write and its fields
  input  wire logic       ctrl_wr,
  input  wire logic       cfg_port_enable,
  input  wire logic       cfg_master_role,
  input  wire logic       cfg_cpol,
  input  wire logic       cfg_cpha,
  input  wire logic       cfg_tx_irq_enable,
  input  wire logic       cfg_rx_irq_enable,
  input  wire logic       cfg_error_irq_enable,
  input  wire logic       cfg_role_fault_enable,
  input  wire logic       request_route_select,
  // software access strobes
  input  wire logic       status_rd,
  input  wire logic       data_rd,
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  // status, data and requests
  output logic            port_enable,
  output logic            master_role_select,
  output logic            tx_empty_flag,
  output logic            rx_full_flag,
  output logic            overflow_flag,
  output logic            role_fault_flag,
  output logic [7:0]      rx_data,
  output logic            tx_irq,
  output logic            rx_err_irq,
  // serial pins
  output logic            sclk_o,
  output logic            sclk_oe,
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe,
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe,
  input  wire logic       ss_n_i
);
  logic                port_en_reg, master_reg, cpol_reg, cpha_reg;
  logic                tx_ie_reg, rx_ie_reg, err_ie_reg, fault_en_reg;
  logic                txe_reg, rxf_reg, ovf_reg, fault_reg;
  logic                rxf_arm_reg, ovf_arm_reg, fault_arm_reg;
  logic [7:0]          tx_buf_reg, sh_reg, rx_data_reg;
  logic                tx_irq_reg, rx_err_irq_reg;
  logic                sclk_reg, sclk_oe_reg, miso_oe_reg, lrst_reg;
  logic [5:0]          sa_reg, sb_reg, sc_reg;
  logic                xfer_reg, in_bit_reg;
  sei_pkg::sei_mstate_t mstate_reg;
  logic [3:0]          half_reg;
  logic [7:0]          div_reg;
  logic [7:0]          link_rx;
  logic                start_tgl, bit1_tgl, end_s_tgl, end_d_tgl;
  logic                ss_n_s, miso_s, ss_fall, ss_rise, slave_en, hold;
  logic [5:0]          ev;
  logic                load, m_step, m_end, bit1_ev, rx_load;
  logic [7:0]          rx_in;
  logic                fault_m, fault_s, fault_set, ovf_set, abort;
  logic [3:0]          half_nx;

  // outputs straight from flip-flops
  assign port_enable        = port_en_reg;
  assign master_role_select = master_reg;
  assign tx_empty_flag      = txe_reg;
  assign rx_full_flag       = rxf_reg;
  assign overflow_flag      = ovf_reg;
  assign role_fault_flag    = fault_reg;
  assign rx_data            = rx_data_reg;
  assign tx_irq             = tx_irq_reg;
  assign rx_err_irq         = rx_err_irq_reg;
  assign sclk_o             = sclk_reg;
  assign sclk_oe            = sclk_oe_reg;
  assign mosi_o             = sh_reg[7];
  assign mosi_oe            = sclk_oe_reg;
  assign miso_oe            = miso_oe_reg;

  // pins and link toggles cross in two flops; third stage feeds edge detect only
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sa_reg <= sei_pkg::SYNC_RST;
      sb_reg <= sei_pkg::SYNC_RST;
      sc_reg <= sei_pkg::SYNC_RST;
    end else begin
      sa_reg <= {start_tgl, end_d_tgl, end_s_tgl, bit1_tgl, miso_i, ss_n_i};
      sb_reg <= sa_reg;
      sc_reg <= sb_reg;
    end
  end

  // decoded crossing events
  assign ev       = sb_reg ^ sc_reg;
  assign ss_n_s   = sb_reg[0];
  assign miso_s   = sb_reg[1];
  assign ss_fall  = sc_reg[0] & ~sb_reg[0];
  assign ss_rise  = ~sc_reg[0] & sb_reg[0];
  assign slave_en = port_en_reg & ~master_reg;
  assign abort    = ~port_en_reg;
  // raw pin as async clear: deselect must freeze the shifter at once
  assign hold     = ss_n_i | ~slave_en;

  // link reset held one cycle past bus reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lrst_reg <= 1'b1;
    end else begin
      lrst_reg <= 1'b0;
    end
  end

  sei_slave_link u_link (
    .link_sclk (link_sclk),
    .hold      (hold),
    .link_rst  (lrst_reg),
    .cpol      (cpol_reg),
    .cpha      (cpha_reg),
    .mosi_i    (mosi_i),
    .miso_o    (miso_o),
    .tx_byte   (sh_reg),
    .rx_byte   (link_rx),
    .start_tgl (start_tgl),
    .bit1_tgl  (bit1_tgl),
    .end_s_tgl (end_s_tgl),
    .end_d_tgl (end_d_tgl)
  );

  assign load = port_en_reg & ~txe_reg & ~data_wr
              & (master_reg ? (mstate_reg == sei_pkg::M_IDLE) : ~xfer_reg);
  assign m_step  = (mstate_reg == sei_pkg::M_RUN) && (div_reg == sei_pkg::HALF_DIV_LAST);
  assign m_end   = m_step && (half_reg == sei_pkg::HALF_FINAL);
  assign half_nx = half_reg + 4'h1;
  // bit 1 captured mid cycle seven
  assign bit1_ev = (m_step && half_nx == sei_pkg::HALF_BIT1 && master_reg)
                 | (ev[2] & slave_en);
  assign rx_load = m_end | (slave_en & (ev[3] | ev[4]));
  assign rx_in   = master_reg ? {sh_reg[6:0], in_bit_reg} : link_rx;
  assign ovf_set = bit1_ev & rxf_reg;

  // fault conditions
  // master sees select low
  assign fault_m   = port_en_reg & master_reg & fault_en_reg & ~ss_n_s;
  assign fault_s   = slave_en & fault_en_reg & ss_rise & xfer_reg;
  assign fault_set = fault_m | fault_s;

  // control bits; a master fault beats a same-cycle enable write
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      port_en_reg  <= sei_pkg::CTRL_RST;
      master_reg   <= sei_pkg::CTRL_RST;
      cpol_reg     <= sei_pkg::CTRL_RST;
      cpha_reg     <= sei_pkg::CTRL_RST;
      tx_ie_reg    <= sei_pkg::CTRL_RST;
      rx_ie_reg    <= sei_pkg::CTRL_RST;
      err_ie_reg   <= sei_pkg::CTRL_RST;
      fault_en_reg <= sei_pkg::CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        port_en_reg  <= cfg_port_enable;
        master_reg   <= cfg_master_role;
        cpol_reg     <= cfg_cpol;
        cpha_reg     <= cfg_cpha;
        tx_ie_reg    <= cfg_tx_irq_enable;
        rx_ie_reg    <= cfg_rx_irq_enable;
        err_ie_reg   <= cfg_error_irq_enable;
        fault_en_reg <= cfg_role_fault_enable;
      end
      if (fault_m) begin
        port_en_reg <= 1'b0;
      end
    end
  end

  // transmit buffer and tx-empty
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      txe_reg    <= sei_pkg::TXE_RST;
      tx_buf_reg <= sei_pkg::BYTE_RST;
    end else begin
      if (data_wr) begin
        tx_buf_reg <= data_wdata;
      end
      if (abort) begin
        txe_reg <= 1'b1;
      end else if (data_wr) begin
        txe_reg <= 1'b0;
      // set the cycle after the move
      end else if (load) begin
        txe_reg <= 1'b1;
      end
    end
  end

  // master serial engine; also holds the slave's outgoing byte
  always_ff @(posedge ref_clk) begin
    if (!rstn || abort) begin
      mstate_reg <= sei_pkg::M_IDLE;
      half_reg   <= sei_pkg::HALF_FIRST;
      div_reg    <= 8'h00;
      sh_reg     <= sei_pkg::BYTE_RST;
      in_bit_reg <= 1'b0;
      sclk_reg   <= cpol_reg;
    end else if (mstate_reg == sei_pkg::M_IDLE) begin
      sclk_reg <= cpol_reg;
      if (load) begin
        sh_reg <= tx_buf_reg;
        if (master_reg) begin
          mstate_reg <= sei_pkg::M_RUN;
          half_reg   <= sei_pkg::HALF_FIRST;
          div_reg    <= 8'h00;
          sclk_reg   <= cpol_reg ^ cpha_reg;
        end
      end else if (rx_load) begin
        // no new byte queued: the received byte goes out next
        sh_reg <= link_rx;
      end
    end else if (m_step) begin
      div_reg <= 8'h00;
      if (m_end) begin
        mstate_reg <= sei_pkg::M_IDLE;
        sclk_reg   <= cpol_reg;
        sh_reg     <= {sh_reg[6:0], in_bit_reg};
      end else begin
        half_reg <= half_nx;
        sclk_reg <= cpol_reg ^ cpha_reg ^ half_nx[0];
        // odd half captures, even half shifts the next bit out
        if (half_nx[0]) begin
          in_bit_reg <= miso_s;
        end else begin
          sh_reg <= {sh_reg[6:0], in_bit_reg};
        end
      end
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // slave transfer window as seen on the bus clock
  always_ff @(posedge ref_clk) begin
    if (!rstn || !slave_en) begin
      xfer_reg <= 1'b0;
    end else if (ss_rise || ev[3] || ev[4]) begin
      xfer_reg <= 1'b0;
    // phase 0 starts at select fall
    // so a bare deselect still faults
    end else if (!cpha_reg && ss_fall) begin
      xfer_reg <= 1'b1;
    // phase 1 starts at first edge
    end else if (cpha_reg && ev[5] && !ss_n_s) begin
      xfer_reg <= 1'b1;
    end
  end

  // receive register, receiver-full and overflow; each flag's set beats its clear, but a data read beats an arming status read
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_data_reg <= sei_pkg::BYTE_RST;
      rxf_reg     <= sei_pkg::FLAG_RST;
      rxf_arm_reg <= sei_pkg::FLAG_RST;
      ovf_reg     <= sei_pkg::FLAG_RST;
      ovf_arm_reg <= sei_pkg::FLAG_RST;
    end else begin
      if (rx_load && !ovf_reg) begin
        rx_data_reg <= rx_in;
        rxf_reg     <= 1'b1;
      end else if (data_rd && rxf_arm_reg) begin
        rxf_reg <= 1'b0;
      end
      if (data_rd) begin
        rxf_arm_reg <= 1'b0;
      end else if (status_rd && rxf_reg) begin
        rxf_arm_reg <= 1'b1;
      end
      if (ovf_set) begin
        ovf_reg <= 1'b1;
      end else if (data_rd && ovf_arm_reg) begin
        ovf_reg <= 1'b0;
      end
      if (data_rd) begin
        ovf_arm_reg <= 1'b0;
      end else if (status_rd && ovf_reg) begin
        ovf_arm_reg <= 1'b1;
      end
    end
  end

  // role fault flag and its two-step clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fault_reg     <= sei_pkg::FLAG_RST;
      fault_arm_reg <= sei_pkg::FLAG_RST;
    end else begin
      if (fault_set) begin
        fault_reg <= 1'b1;
      // clear only if no fault in between
      end else if (ctrl_wr && fault_arm_reg) begin
        fault_reg <= 1'b0;
      end
      if (fault_set || ctrl_wr) begin
        fault_arm_reg <= 1'b0;
      end else if (status_rd && fault_reg) begin
        fault_arm_reg <= 1'b1;
      end
    end
  end

  // interrupt requests
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_irq_reg     <= 1'b0;
      rx_err_irq_reg <= 1'b0;
    end else begin
      tx_irq_reg <= txe_reg & tx_ie_reg & port_en_reg & ~request_route_select;
      rx_err_irq_reg <= (rxf_reg & rx_ie_reg & ~request_route_select)
                      | (err_ie_reg & (ovf_reg | fault_reg));
    end
  end

  // pin directions; a disabled port hands the pins back
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sclk_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      // master drives clock and data out
      sclk_oe_reg <= port_en_reg & master_reg;
      miso_oe_reg <= slave_en & ~ss_n_s;
    end
  end

  // checks on the bus clock
  AST_TXE_REFILL: assert property (@(posedge ref_clk) disable iff (!rstn)
    load && !data_wr |-> ##[1:2] txe_reg)
    else $error("tx-empty not set again after buffer move");
  AST_SLAVE_NOLOAD: assert property (@(posedge ref_clk) disable iff (!rstn)
    slave_en && xfer_reg |-> !load)
    else $error("slave reloaded during an active byte");
  AST_OVF_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
    bit1_ev && rxf_reg |=> ovf_reg)
    else $error("overflow missed at bit-1 capture");
  AST_RX_BLOCK: assert property (@(posedge ref_clk) disable iff (!rstn)
    ovf_reg |=> $stable(rx_data_reg) && !$rose(rxf_reg))
    else $error("byte accepted while overflow pending");
  AST_OVF_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
    status_rd && ovf_reg ##1 !data_rd ##1 data_rd && !ovf_set |=> !ovf_reg)
    else $error("overflow not cleared by status then data read");
  AST_FAULT_GATED: assert property (@(posedge ref_clk) disable iff (!rstn)
    !fault_reg ##1 fault_reg |-> $past(fault_en_reg))
    else $error("role fault set without enable");
  AST_MFAULT: assert property (@(posedge ref_clk) disable iff (!rstn)
    fault_m |=> !port_en_reg && fault_reg ##1 txe_reg && !sclk_oe_reg)
    else $error("master fault did not shut the port");
  AST_ROLE_KEPT: assert property (@(posedge ref_clk) disable iff (!rstn)
    fault_set && !ctrl_wr |=> $stable(master_reg))
    else $error("role bit changed by a fault");
  AST_TX_IRQ: assert property (@(posedge ref_clk) disable iff (!rstn)
    (txe_reg && tx_ie_reg && port_en_reg && !request_route_select) [*2] |-> tx_irq_reg)
    else $error("tx request missing");
  AST_ERR_IRQ: assert property (@(posedge ref_clk) disable iff (!rstn)
    (err_ie_reg && (ovf_reg || fault_reg)) |=> rx_err_irq_reg)
    else $error("error request missing");
  AST_MISO_Z: assert property (@(posedge ref_clk) disable iff (!rstn)
    ss_n_s [*2] |-> !miso_oe_reg)
    else $error("data-in driven while deselected");
endmodule // sei_error_irq

// >>> tb/sei_peer.sv
`timescale 1ns/10ps
// far-side peer: master frames for a slave dut, slave shifter for a master dut
module sei_peer (
  // wire levels
  input  wire logic       sclk_w,
  input  wire logic       mosi_w,
  input  wire logic       miso_w,
  // lines it drives
  output logic            p_sclk,
  output logic            p_mosi,
  output logic            p_miso,
  output logic            p_ss_n,
  output logic [7:0]      got_byte
);
  logic [7:0] sh;
  // select idles high so a master dut sees no fault
  initial begin
    {p_sclk, p_mosi, p_miso, p_ss_n, got_byte, sh} = 20'h30000;
  end
  // slave side: take on rise, next bit on fall
  always @(posedge sclk_w) got_byte <= {got_byte[6:0], mosi_w};
  // shifted-in bits are inverted so a stale line never matches
  always @(negedge sclk_w) begin
    sh <= {sh[6:0], ~sh[7]};
    p_miso <= sh[6];
  end
  task automatic load(input logic [7:0] b);
    sh = b;
    p_miso = b[7];
  endtask
  task automatic set_ss(input logic v);
    #1 p_ss_n = v;
  endtask
  // master frame formats
  // clock stands still outside the frame; n from 1 to 7 aborts mid byte, n of 0 gives a bare select
  task automatic frame(input logic [7:0] b, input logic ph, input int n,
                       output logic [7:0] g);
    g = 8'h00;
    #1 p_ss_n = 1'b0;
    // the slave needs a few bus cycles to see select and drive its data pin
    #20;
    for (int i = 7; i >= 8 - n; i--) begin
      if (!ph) p_mosi = b[i];
      // phase 0 captures just before the rising edge, never on the falling one
      #3 if (!ph) g = {g[6:0], miso_w};
      p_sclk = 1'b1;
      #1 if (ph) p_mosi = b[i];
      #2 if (ph) g = {g[6:0], miso_w};
      p_sclk = 1'b0;
    end
    #7 p_mosi = ~p_mosi;
    p_ss_n = 1'b1;
  endtask
endmodule // sei_peer

// >>> tb/test_sei_error_irq.sv
`timescale 1ns/10ps
module test_sei_error_irq;
  logic       ref_clk, rstn, ctrl_wr, cfg_port_enable, cfg_master_role, cfg_cpol, cfg_cpha;
  logic       cfg_tx_irq_enable, cfg_rx_irq_enable, cfg_error_irq_enable;
  logic       cfg_role_fault_enable, request_route_select, status_rd, data_rd, data_wr;
  logic       port_enable, master_role_select, tx_empty_flag, rx_full_flag, overflow_flag;
  logic       role_fault_flag, tx_irq, rx_err_irq, sclk_o, sclk_oe, mosi_o, mosi_oe;
  logic       miso_o, miso_oe, p_sclk, p_mosi, p_miso, p_ss_n, rxf_d;
  logic [7:0] data_wdata, rx_data, got_byte, g, b;
  logic [7:0] exp_q[$];
  int         err_count, checks, n;
  always #2.5 ref_clk = ~ref_clk;
  // pin levels from the dut's enables; the peer drives otherwise
  wire sclk_w = sclk_oe ? sclk_o : p_sclk;
  wire mosi_w = mosi_oe ? mosi_o : p_mosi;
  wire miso_w = miso_oe ? miso_o : p_miso;
  sei_peer peer_u (.sclk_w, .mosi_w, .miso_w, .p_sclk, .p_mosi, .p_miso, .p_ss_n, .got_byte);
  sei_error_irq dut_u (.ref_clk, .rstn, .link_sclk(sclk_w), .ctrl_wr, .cfg_port_enable,
    .cfg_master_role, .cfg_cpol, .cfg_cpha, .cfg_tx_irq_enable, .cfg_rx_irq_enable,
    .cfg_error_irq_enable, .cfg_role_fault_enable, .request_route_select, .status_rd,
    .data_rd, .data_wr, .data_wdata, .port_enable, .master_role_select, .tx_empty_flag,
    .rx_full_flag, .overflow_flag, .role_fault_flag, .rx_data, .tx_irq, .rx_err_irq,
    .sclk_o, .sclk_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o,
    .miso_oe, .ss_n_i(p_ss_n));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  // fields {enable, master, phase, tx ie, rx ie, err ie, fault en}; polarity stays 0
  task automatic cfg(input logic [6:0] v);
    @(posedge ref_clk);
    {cfg_port_enable, cfg_master_role, cfg_cpha, cfg_tx_irq_enable, cfg_rx_irq_enable,
     cfg_error_irq_enable, cfg_role_fault_enable} <= v;
    ctrl_wr <= 1'b1;
    @(posedge ref_clk);
    ctrl_wr <= 1'b0;
    tk(3);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge ref_clk);
    {status_rd, data_rd, data_wr} <= v;
    @(posedge ref_clk);
    {status_rd, data_rd, data_wr} <= 3'b000;
  endtask
  // bounded wait on tx-empty (0) or receiver-full (1)
  task automatic wait_hi(input int sel, input int lim);
    // look one edge on, so a flag updated at the current edge is not missed
    for (n = 0; n < lim; n++) begin
      tk(1);
      if ((sel ? rx_full_flag : tx_empty_flag) === 1'b1) break;
    end
    if (n == lim) begin
      err_count++;
      $display("CHECK FAILED wait %0d expected 1 seen timeout", sel);
      tally_and_finish();
    end
  endtask
  // each new received byte pairs with the oldest note
  always @(posedge ref_clk) begin
    rxf_d <= rx_full_flag;
    if (rx_full_flag === 1'b1 && rxf_d === 1'b0) chk("rx_data", exp_q.pop_front(), rx_data);
  end
  initial begin
    {ref_clk, rstn, ctrl_wr, cfg_port_enable, cfg_master_role, cfg_cpol, cfg_cpha} = 7'h00;
    {cfg_tx_irq_enable, cfg_rx_irq_enable, cfg_error_irq_enable, cfg_role_fault_enable} = 4'h0;
    {request_route_select, status_rd, data_rd, data_wr, rxf_d, data_wdata} = 13'h0000;
    {err_count, checks} = 0;
    void'($urandom(43245));
    tk(2);
    rstn <= 1'b1;
    tk(1);
    chk("reset state", 8'h40, {port_enable, tx_empty_flag, rx_full_flag, overflow_flag,
        role_fault_flag, tx_irq, rx_err_irq, sclk_oe});
    // master byte exchange; peer answers with its own byte
    b = 8'($urandom);
    peer_u.load(b);
    exp_q.push_back(b);
    cfg(7'h6f);
    data_wdata <= 8'($urandom);
    pulse(3'b001);
    wait_hi(0, sei_pkg::TXE_REFILL_MAX_CYC + 1);
    tk(3);
    chk("tx_irq and pins", 8'h0d, {4'h0, tx_irq, sclk_oe, miso_oe, mosi_oe});
    request_route_select <= 1'b1;
    tk(3);
    chk("routed tx_irq", 8'h00, {7'h00, tx_irq});
    request_route_select <= 1'b0;
    wait_hi(1, 200);
    chk("mosi byte", data_wdata, got_byte);
    tk(2);
    chk("rx request", 8'h01, {7'h00, rx_err_irq});
    pulse(3'b100);
    pulse(3'b010);
    tk(2);
    chk("rx_full cleared", 8'h00, {7'h00, rx_full_flag});
    // master select fault, first with the fault enable off
    cfg(7'h6e);
    peer_u.set_ss(1'b0);
    tk(8);
    chk("fault blocked", 8'h00, {7'h00, role_fault_flag});
    cfg(7'h6f);
    tk(4);
    chk("master fault", 8'hb4, {role_fault_flag, port_enable, tx_empty_flag,
        master_role_select, sclk_oe, rx_err_irq, 2'b00});
    peer_u.set_ss(1'b1);
    tk(4);
    pulse(3'b100);
    cfg(7'h00);
    chk("fault cleared", 8'h00, {7'h00, role_fault_flag});
    // slave, phase 0: receive, then overflow
    cfg(7'h47);
    data_wdata <= 8'($urandom);
    pulse(3'b001);
    tk(3);
    b = 8'($urandom);
    exp_q.push_back(b);
    peer_u.frame(b, 1'b0, 8, g);
    wait_hi(1, 40);
    tk(3);
    chk("miso byte", data_wdata, g);
    chk("miso released", 8'h00, {7'h00, miso_oe});
    peer_u.frame(~b, 1'b0, 8, g);
    tk(10);
    chk("overflow", 8'h03, {6'h00, overflow_flag, rx_err_irq});
    chk("old byte kept", b, rx_data);
    pulse(3'b100);
    pulse(3'b010);
    tk(2);
    chk("overflow cleared", 8'h00, {6'h00, overflow_flag, rx_full_flag});
    peer_u.frame(b, 1'b0, 0, g);
    tk(6);
    chk("slave fault", 8'h0d, {4'h0, role_fault_flag, port_enable, master_role_select,
        rx_err_irq});
    pulse(3'b100);
    cfg(7'h00);
    cfg(7'h57);
    chk("fault cleared", 8'h00, {7'h00, role_fault_flag});
    // slave, phase 1
    peer_u.frame(b, 1'b1, 0, g);
    tk(6);
    chk("phase 1 bare select", 8'h00, {7'h00, role_fault_flag});
    b = 8'($urandom);
    exp_q.push_back(b);
    peer_u.frame(b, 1'b1, 8, g);
    wait_hi(1, 40);
    peer_u.frame(b, 1'b1, 4, g);
    tk(6);
    chk("mid byte deselect", 8'h01, {7'h00, role_fault_flag});
    tally_and_finish();
  end
endmodule // test_sei_error_irq
